// file: ied_dispatch.sv
// Interrupt enable registers, local flags and forced-call dispatch.
//
// Behaviour
// - No interrupt is taken while the global enable bit 7 of enable register A is 0; otherwise each source is gated by its own enable.
// - Enable register A holds the sleep timer, cipher, serial1 rx, serial0 rx, converter and radio FIFO enables at bits 5..0, reset 0, bit 6 reads 0.
// - Enable register B holds port0, timer4..timer1 and DMA enables at bits 5..0, reset 0, bits 7:6 read 0.
// - Enable register C holds watchdog, port1, serial1 tx, serial0 tx, port2 and radio general enables at bits 5..0, reset 0, bits 7:6 read 0.
// - Taking an interrupt sends the core to the vector of the requesting source.
// - An active service is preempted only by a strictly higher priority.
// - Return from service ends the active service level so the core resumes where it left.
// - A source event sets its flag whatever the enable state.
// - An enabled set flag is taken at the next instruction boundary by a forced long call.
// - A request no higher than the active service stays pending until it becomes the highest.
// - The fastest response is seven cycles, one of detection and six of forced call.
// - Flags of serial1 rx, converter, serial0 rx and radio FIFO sit at bits 7, 5, 3, 1, reset 0, and clear by hardware on vectoring.
// - Bits 2 and 0 of the flag register reset to 1 and are writable detection mode bits.
// - Eighteen sources are served, each with its own flag and enable.
// - Vectors start at 03h for source 0 and step by 8 up to 8Bh.
`timescale 1ns/1ps
`default_nettype none
module ied_dispatch #(
  parameter int NSRC = ied_pkg::NUM_SRC
) (
  // Clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 nrst_i,
  // Special function register port
  input  wire logic [7:0]           sfr_addr_i,
  input  wire logic                 sfr_wr_i,
  input  wire logic [7:0]           sfr_wdata_i,
  input  wire logic                 sfr_rd_i,
  output logic [7:0]                sfr_rdata_o,
  // Sources
  input  wire logic [3:0]           local_event_i,
  input  wire logic [NSRC-5:0]      ext_flag_i,
  input  wire logic [NSRC*2-1:0]    src_prio_i,
  // Core handshake
  input  wire logic                 instr_boundary_i,
  input  wire logic                 return_from_service_i,
  output logic                      call_busy_o,
  output logic                      vec_load_o,
  output logic [7:0]                vec_addr_o,
  output logic [NSRC-1:0]           flag_clr_o,
  output logic [3:0]                in_service_o
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic                  global_irq_enable_r, global_irq_enable_nxt;
  logic [5:0]            ena_r, ena_nxt, enb_r, enb_nxt, enc_r, enc_nxt;
  logic [3:0]            pend_r, pend_nxt;
  logic                  mode_hi_r, mode_hi_nxt, mode_lo_r, mode_lo_nxt;
  logic [7:0]            rdata_r, rdata_nxt, flags_view;
  logic [3:0]            hw_clr;

  // Local flags in source order: radio FIFO, converter, serial0, serial1.
  assign flags_view = {pend_r[3], 1'b0, pend_r[1], 1'b0,
                       pend_r[2], mode_hi_r, pend_r[0], mode_lo_r};

  // Register writes; an event beats both a write and a hardware clear.
  always_comb
  begin
    global_irq_enable_nxt = global_irq_enable_r;
    ena_nxt     = ena_r;
    enb_nxt     = enb_r;
    enc_nxt     = enc_r;
    mode_hi_nxt = mode_hi_r;
    mode_lo_nxt = mode_lo_r;
    pend_nxt    = pend_r & ~hw_clr;
    if (sfr_wr_i)
    begin
      case (sfr_addr_i)
        ied_pkg::ADDR_ENABLE_A:
        begin
          global_irq_enable_nxt = sfr_wdata_i[ied_pkg::GLOBAL_EN_BIT];
          ena_nxt = sfr_wdata_i[5:0];
        end
        ied_pkg::ADDR_ENABLE_B: enb_nxt = sfr_wdata_i[5:0];
        ied_pkg::ADDR_ENABLE_C: enc_nxt = sfr_wdata_i[5:0];
        ied_pkg::ADDR_FLAGS_A:
        begin
          pend_nxt = {sfr_wdata_i[ied_pkg::FLG_SER1_RX_BIT],
                      sfr_wdata_i[ied_pkg::FLG_SER0_RX_BIT],
                      sfr_wdata_i[ied_pkg::FLG_CONV_BIT],
                      sfr_wdata_i[ied_pkg::FLG_RADIO_BIT]};
          mode_hi_nxt = sfr_wdata_i[ied_pkg::FLG_MODE_HI_BIT];
          mode_lo_nxt = sfr_wdata_i[ied_pkg::FLG_MODE_LO_BIT];
        end
        default: ;
      endcase
    end
    pend_nxt = pend_nxt | local_event_i;
  end

  // Reads are registered; unmapped addresses answer zero.
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        ied_pkg::ADDR_ENABLE_A:
          rdata_nxt = {global_irq_enable_r, 1'b0, ena_r};
        ied_pkg::ADDR_ENABLE_B: rdata_nxt = {2'b00, enb_r};
        ied_pkg::ADDR_ENABLE_C: rdata_nxt = {2'b00, enc_r};
        ied_pkg::ADDR_FLAGS_A:  rdata_nxt = flags_view;
        default:                rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      global_irq_enable_r <= 1'b0;
      ena_r     <= ied_pkg::ENABLE_RST;
      enb_r     <= ied_pkg::ENABLE_RST;
      enc_r     <= ied_pkg::ENABLE_RST;
      pend_r    <= 4'h0;
      mode_hi_r <= ied_pkg::MODE_RST;
      mode_lo_r <= ied_pkg::MODE_RST;
      rdata_r   <= 8'h00;
    end
    else
    begin
      global_irq_enable_r <= global_irq_enable_nxt;
      ena_r     <= ena_nxt;
      enb_r     <= enb_nxt;
      enc_r     <= enc_nxt;
      pend_r    <= pend_nxt;
      mode_hi_r <= mode_hi_nxt;
      mode_lo_r <= mode_lo_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign sfr_rdata_o = rdata_r;

  // ----------------------------------------------------------------------
  // Request selection
  // ----------------------------------------------------------------------
  logic [NSRC-1:0] req_all, en_all;
  logic            pick_valid;
  logic [4:0]      pick_idx;
  logic [1:0]      pick_prio;
  logic [3:0]      isr_r, isr_nxt;
  logic            svc_any;
  logic [1:0]      svc_lvl;
  logic            take;

  assign req_all = {ext_flag_i, pend_r};
  assign en_all  = {enc_r[5], enc_r[0], enc_r[4], enc_r[3], enb_r,
                    enc_r[2], enc_r[1], ena_r};

  ied_pick #(
    .N  (NSRC),
    .PW (ied_pkg::PRIO_W)
  ) u_pick (
    .req_i   (req_all),
    .en_i    (en_all),
    .prio_i  (src_prio_i),
    .valid_o (pick_valid),
    .idx_o   (pick_idx),
    .prio_o  (pick_prio)
  );

  // Highest level in service; a lower request simply waits in its flag.
  always_comb
  begin
    svc_any = |isr_r;
    svc_lvl = 2'd0;
    for (int l = 0; l < ied_pkg::NUM_LVL; l++)
    begin
      if (isr_r[l])
      begin
        svc_lvl = 2'(l);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Dispatch sequence
  // ----------------------------------------------------------------------
  ied_pkg::ied_state_t state_r, state_nxt;
  ied_pkg::ied_call_t  call_r, call_nxt;
  logic [2:0]          cnt_r, cnt_nxt;
  logic                busy_r, busy_nxt, load_r, load_nxt;
  logic [7:0]          vec_r, vec_nxt;
  logic [NSRC-1:0]     clr_r, clr_nxt;
  logic                call_end;

  assign take = instr_boundary_i && global_irq_enable_r && pick_valid &&
                (!svc_any || pick_prio > svc_lvl);
  assign call_end = (state_r == ied_pkg::st_call) && (cnt_r == 3'd0);
  assign hw_clr   = call_end ? clr_nxt[3:0] : 4'h0;

  always_comb
  begin
    state_nxt = state_r;
    call_nxt  = call_r;
    cnt_nxt   = cnt_r;
    load_nxt  = 1'b0;
    vec_nxt   = vec_r;
    clr_nxt   = '0;
    isr_nxt   = isr_r;
    if (return_from_service_i && svc_any)
    begin
      isr_nxt[svc_lvl] = 1'b0;
    end
    case (state_r)
      ied_pkg::st_idle:
      begin
        if (take)
        begin
          call_nxt.src  = pick_idx;
          call_nxt.prio = pick_prio;
          call_nxt.vec  = ied_pkg::VEC_BASE +
                          8'(pick_idx) * ied_pkg::VEC_STEP;
          state_nxt     = ied_pkg::st_detect;
        end
      end
      ied_pkg::st_detect:
      begin
        cnt_nxt   = 3'(ied_pkg::CALL_CYC - 1);
        state_nxt = ied_pkg::st_call;
      end
      ied_pkg::st_call:
      begin
        cnt_nxt = cnt_r - 3'd1;
        if (cnt_r == 3'd0)
        begin
          state_nxt = ied_pkg::st_idle;
          load_nxt  = 1'b1;
          vec_nxt   = call_r.vec;
          clr_nxt[call_r.src] = 1'b1;
          isr_nxt[call_r.prio] = 1'b1;
        end
      end
      default: state_nxt = ied_pkg::st_idle;
    endcase
    busy_nxt = (state_nxt != ied_pkg::st_idle);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      state_r <= ied_pkg::st_idle;
      call_r  <= '0;
      cnt_r   <= 3'd0;
      busy_r  <= 1'b0;
      load_r  <= 1'b0;
      vec_r   <= 8'h00;
      clr_r   <= '0;
      isr_r   <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      call_r  <= call_nxt;
      cnt_r   <= cnt_nxt;
      busy_r  <= busy_nxt;
      load_r  <= load_nxt;
      vec_r   <= vec_nxt;
      clr_r   <= clr_nxt;
      isr_r   <= isr_nxt;
    end
  end

  assign call_busy_o  = busy_r;
  assign vec_load_o   = load_r;
  assign vec_addr_o   = vec_r;
  assign flag_clr_o   = clr_r;
  assign in_service_o = isr_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Busy without the jump pulse, so the call steps are counted apart.
  logic busy_o_hi;
  assign busy_o_hi = busy_r && !load_r;

  sequence s_call_seq;
    busy_o_hi [*7] ##1 load_r;
  endsequence

  property p_latency;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (state_r == ied_pkg::st_idle && take) |=> s_call_seq;
  endproperty
  a_latency: assert property (p_latency)
    else $error("forced call did not finish in seven cycles");

  property p_no_take_disabled;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (state_r == ied_pkg::st_idle && !global_irq_enable_r) |=>
      state_r == ied_pkg::st_idle;
  endproperty
  a_no_take_disabled: assert property (p_no_take_disabled)
    else $error("interrupt taken with global enable off");

  property p_vector;
    @(posedge core_clk_i) disable iff (!nrst_i)
    load_r |-> vec_r == ied_pkg::VEC_BASE +
               8'($past(call_r.src)) * ied_pkg::VEC_STEP;
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector address does not match source");

  property p_event_sets;
    @(posedge core_clk_i) disable iff (!nrst_i)
    local_event_i[0] |=> pend_r[0];
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("source event did not set its flag");

  property p_hw_clear;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (load_r && clr_r[1] && !$past(local_event_i[1]) &&
     !$past(sfr_wr_i)) |-> !pend_r[1];
  endproperty
  a_hw_clear: assert property (p_hw_clear)
    else $error("local flag not cleared on vectoring");

  property p_preempt;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (state_r == ied_pkg::st_detect && $past(svc_any)) |->
      call_r.prio > $past(svc_lvl);
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("service preempted by equal or lower priority");

  property p_bit6_zero;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (sfr_rd_i && sfr_addr_i == ied_pkg::ADDR_ENABLE_A) |=> !rdata_r[6];
  endproperty
  a_bit6_zero: assert property (p_bit6_zero)
    else $error("unused enable bit read as one");

  property p_upper_zero;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (sfr_rd_i && (sfr_addr_i == ied_pkg::ADDR_ENABLE_B ||
                  sfr_addr_i == ied_pkg::ADDR_ENABLE_C)) |=>
      rdata_r[7:6] == 2'b00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unused enable bits read as one");

  property p_mode_reset;
    @(posedge core_clk_i)
    !nrst_i |=> (mode_hi_r && mode_lo_r);
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("detection mode bits not reset to one");

  property p_return;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (return_from_service_i && svc_any && !call_end) |=>
      !isr_r[$past(svc_lvl)];
  endproperty
  a_return: assert property (p_return)
    else $error("return did not end the active level");

endmodule // ied_dispatch
`default_nettype wire

// file: ied_pkg.sv
// Shared constants and types of the interrupt enable and dispatch block.
package ied_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS_A  = 8'h88;
  localparam logic [7:0] ADDR_ENABLE_C = 8'h9a;
  localparam logic [7:0] ADDR_ENABLE_A = 8'ha8;
  localparam logic [7:0] ADDR_ENABLE_B = 8'hb8;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         GLOBAL_EN_BIT   = 7;
  localparam int         FLG_SER1_RX_BIT = 7;
  localparam int         FLG_CONV_BIT    = 5;
  localparam int         FLG_SER0_RX_BIT = 3;
  localparam int         FLG_MODE_HI_BIT = 2;
  localparam int         FLG_RADIO_BIT   = 1;
  localparam int         FLG_MODE_LO_BIT = 0;
  localparam logic [5:0] ENABLE_RST      = 6'h00;
  localparam logic       MODE_RST        = 1'b1;

  // ----------------------------------------------------------------------
  // Sources, vectors and timing
  // ----------------------------------------------------------------------
  localparam int         NUM_SRC     = 18;
  localparam int         NUM_LOCAL   = 4;
  localparam int         PRIO_W      = 2;
  localparam int         NUM_LVL     = 4;
  localparam logic [7:0] VEC_BASE    = 8'h03;
  localparam logic [7:0] VEC_STEP    = 8'h08;
  localparam int         DETECT_CYC  = 1;
  localparam int         CALL_CYC    = 6;

  // Dispatch states.
  typedef enum logic [1:0] {st_idle, st_detect, st_call} ied_state_t;

  // One chosen request on its way to the core.
  typedef struct packed {
    logic [4:0]        src;
    logic [PRIO_W-1:0] prio;
    logic [7:0]        vec;
  } ied_call_t;

endpackage

// file: ied_pick.sv
// Picks the highest priority enabled request, lowest source first on a tie.
`timescale 1ns/1ps
`default_nettype none
module ied_pick #(
  parameter int N  = 18,
  parameter int PW = 2
) (
  // Requests, enables and priorities
  input  wire logic [N-1:0]    req_i,
  input  wire logic [N-1:0]    en_i,
  input  wire logic [N*PW-1:0] prio_i,
  // Winner
  output logic                 valid_o,
  output logic [4:0]           idx_o,
  output logic [PW-1:0]        prio_o
);

  // Scan downward so that an equal priority at a lower index replaces the
  // current choice; this gives the lowest source number on ties.
  always_comb
  begin
    valid_o = 1'b0;
    idx_o   = 5'h00;
    prio_o  = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_i[i] && en_i[i] &&
          (!valid_o || prio_i[i*PW +: PW] >= prio_o))
      begin
        valid_o = 1'b1;
        idx_o   = 5'(i);
        prio_o  = prio_i[i*PW +: PW];
      end
    end
  end

endmodule // ied_pick
`default_nettype wire

// file: ied_core_model.sv
// Behavioural core and peripheral side facing the dispatch block.
`timescale 1ns/1ps
`default_nettype none
module ied_core_model (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // Bench commands
  input  wire logic        run_i,
  input  wire logic        slow_i,
  input  wire logic        ret_i,
  input  wire logic [13:0] ext_set_i,
  // Dispatch side
  input  wire logic        vec_load_i,
  input  wire logic [13:0] flag_clr_i,
  output logic             boundary_o,
  output logic             ret_o,
  output logic [13:0]      ext_flag_o
);
  logic [1:0] cnt_r;

  // No boundary in the jump cycle, the core is busy fetching the vector.
  assign boundary_o = run_i && (cnt_r == 2'd0) && !vec_load_i;

  // Slow mode spaces boundaries four cycles apart, like long instructions.
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i || !run_i)
      cnt_r <= 2'd0;
    else
      cnt_r <= slow_i ? cnt_r + 2'd1 : 2'd0;
  end

  // Far flags of sources 4..17; a new event wins over the clear.
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      ext_flag_o <= 14'h0000;
      ret_o      <= 1'b0;
    end
    else
    begin
      ext_flag_o <= (ext_flag_o & ~flag_clr_i) | ext_set_i;
      ret_o      <= ret_i;
    end
  end
endmodule // ied_core_model
`default_nettype wire

// file: testbench.sv
// Self-checking testbench of the interrupt enable and dispatch block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk_i = 1'b0;
  logic        nrst_i     = 1'b0;
  logic [7:0]  sfr_addr   = 8'h00;
  logic [7:0]  sfr_wdata  = 8'h00;
  logic        sfr_wr     = 1'b0;
  logic        sfr_rd     = 1'b0;
  logic [3:0]  local_ev   = 4'h0;
  logic [13:0] ext_set    = 14'h0000;
  logic [35:0] src_prio   = 36'h000000000;
  logic        run        = 1'b0;
  logic        slow       = 1'b0;
  logic        ret        = 1'b0;
  logic [7:0]  rdata;
  logic [7:0]  vec_addr;
  logic [17:0] flag_clr;
  logic [3:0]  in_svc;
  logic [13:0] ext_flag;
  logic        boundary;
  logic        ret_pulse;
  logic        busy;
  logic        vec_load;
  logic [7:0]  rnd;
  // Bench model state, integers and a stack of active levels.
  int en[18];
  int pend[18];
  int prio[18];
  int svc[$];
  int ge;
  int n_errors;
  int checked;
  int en_bit[18] = '{0,1,2,3,4,5,1,2,0,1,2,3,4,5,3,4,0,5};
  int en_reg[18] = '{1,1,1,1,1,1,3,3,2,2,2,2,2,2,3,3,3,3};
  logic [7:0] addrs[4] = '{8'h88, 8'ha8, 8'hb8, 8'h9a};
  logic [7:0] masks[4] = '{8'haf, 8'hbf, 8'h3f, 8'h3f};

  // --------------------------------------------------------------------
  // Clock, design and partner
  // --------------------------------------------------------------------
  always #5 core_clk_i = ~core_clk_i;

  // Priorities follow the model one edge later, well before any boundary.
  always @(posedge core_clk_i)
    for (int i = 0; i < 18; i++)
      src_prio[2*i +: 2] <= prio[i][1:0];

  ied_dispatch ied_dispatch_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wdata),
    .sfr_rd_i(sfr_rd), .sfr_rdata_o(rdata), .local_event_i(local_ev),
    .ext_flag_i(ext_flag), .src_prio_i(src_prio),
    .instr_boundary_i(boundary), .return_from_service_i(ret_pulse),
    .call_busy_o(busy), .vec_load_o(vec_load), .vec_addr_o(vec_addr),
    .flag_clr_o(flag_clr), .in_service_o(in_svc));

  ied_core_model ied_core_model_i (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .run_i(run), .slow_i(slow), .ret_i(ret),
    .ext_set_i(ext_set), .vec_load_i(vec_load),
    .flag_clr_i(flag_clr[17:4]), .boundary_o(boundary),
    .ret_o(ret_pulse), .ext_flag_o(ext_flag));

  // --------------------------------------------------------------------
  // Model functions and bus tasks
  // --------------------------------------------------------------------
  function automatic logic [7:0] en_val(int r);
    logic [7:0] v;
    v = 8'h00;
    for (int s = 0; s < 18; s++)
      if (en_reg[s] == r && en[s] != 0) v[en_bit[s]] = 1'b1;
    if (r == 1) v[7] = (ge != 0);
    return v;
  endfunction

  function automatic logic [7:0] flags_exp();
    return {pend[3] != 0, 1'b0, pend[1] != 0, 1'b0, pend[2] != 0, 1'b1,
            pend[0] != 0, 1'b1};
  endfunction

  // Highest priority above the active level; strict compare keeps ties low.
  function automatic int pick();
    int b;
    int cur;
    b = -1;
    cur = (svc.size() > 0) ? svc[svc.size()-1] : -1;
    for (int s = 0; s < 18; s++)
      if (ge != 0 && en[s] != 0 && pend[s] != 0 && prio[s] > cur &&
          (b < 0 || prio[s] > prio[b])) b = s;
    return b;
  endfunction

  function automatic logic [3:0] svc_mask();
    logic [3:0] m;
    m = 4'h0;
    foreach (svc[i]) m[svc[i]] = 1'b1;
    return m;
  endfunction

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk_i);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd <= 1'b0;
    @(negedge core_clk_i);
    chk($sformatf("reg_%h", a), exp, rdata);
  endtask

  task automatic set_en();
    for (int r = 1; r < 4; r++) wr(addrs[r], en_val(r));
  endtask

  task automatic raise(int s);
    @(posedge core_clk_i);
    if (s < 4) local_ev[s] <= 1'b1;
    else ext_set[s-4] <= 1'b1;
    @(posedge core_clk_i);
    local_ev <= 4'h0;
    ext_set  <= 14'h0000;
    pend[s] = 1;
  endtask

  // Boundaries run until a call lands or forty cycles pass without one.
  task automatic take(int fast);
    int n;
    int e;
    int nb;
    n = 0;
    nb = 0;
    e = pick();
    @(posedge core_clk_i);
    slow <= (fast == 0);
    run  <= 1'b1;
    while (vec_load !== 1'b1 && n < 40)
    begin
      @(negedge core_clk_i);
      n++;
      if (busy === 1'b1) nb++;
    end
    chk("busy_cycles", (e < 0) ? 0 : 7, nb);
    if (e < 0) chk("idle_cycles", 40, n);
    else
    begin
      chk("vec_addr", 8'h03 + 8 * e, vec_addr);
      chk("flag_clr", 32'd1 << e, flag_clr);
      if (fast != 0) chk("latency", 9, n);
      svc.push_back(prio[e]);
      pend[e] = 0;
      chk("in_service", svc_mask(), in_svc);
    end
    @(posedge core_clk_i);
    run <= 1'b0;
  endtask

  task automatic leave();
    @(posedge core_clk_i);
    ret <= 1'b1;
    @(posedge core_clk_i);
    ret <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    void'(svc.pop_back());
    @(negedge core_clk_i);
    chk("in_service", svc_mask(), in_svc);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h44da));
    repeat (12) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 4; i++) rd(addrs[i], i == 0 ? 8'h05 : 8'h00);
    rd(8'hc0, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      rnd = 8'($urandom) | ((i == 0) ? 8'h05 : 8'h00);
      wr(addrs[i], rnd);
      rd(addrs[i], rnd & masks[i]);
    end
    wr(addrs[0], 8'h05);
    set_en();
    en[1] = 1;
    set_en();
    raise(1);
    take(1);
    rd(addrs[0], flags_exp());
    ge = 1;
    set_en();
    take(1);
    rd(addrs[0], flags_exp());
    leave();
    for (int s = 0; s < 18; s++)
    begin
      en = '{default: 0};
      en[s] = 1;
      prio[s] = $urandom_range(3, 0);
      set_en();
      raise(s);
      take(s % 3 == 0);
      leave();
    end
    en = '{default: 0};
    prio = '{default: 0};
    en[2] = 1;
    en[5] = 1;
    en[9] = 1;
    en[12] = 1;
    prio[2] = 1;
    prio[5] = 1;
    prio[9] = 1;
    prio[12] = 2;
    set_en();
    raise(2);
    take(1);
    raise(9);
    raise(5);
    take(1);
    raise(12);
    take(1);
    leave();
    take(0);
    leave();
    take(0);
    leave();
    take(1);
    leave();
    summarize();
  end

  // A hang is cut short far beyond the several hundred cycles the run needs.
  initial
  begin
    #200us;
    n_errors++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
